/* File: usb_host_buffer_select.v */
// Buffer selector and status write-back of a low/full speed USB host,
// with an APB register file and a simple packet request port.
// Assumes one clock pclk; the packet engine answers each request once.
//
// Overview of operation
// - Software transfers and timed interrupt polls
// - Interrupt polls always single buffered
// - Selector not cleared before interrupt polls
// - Poll completion may show buffer one selected
// - One selector, toggles as each packet completes
// - Selector toggles in single-buffered mode too
// - Multi-packet above 8 or 64 bytes
// - Status written to half named by selector
// - Single mode fetch ignores the selector
// - Record selector at done in pending flags
//
// The APB slave port and the register addresses were left to the implementer.
`include "usb_host_buffer_select_defs.vh"
`timescale 1ns/10ps
`default_nettype none
module usb_host_buffer_select
#(
	parameter INTERVAL_W = 16
)
(
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	output reg pkt_start,
	output reg [`PKT_W-1:0] pkt_size,
	output reg pkt_is_poll,
	input wire pkt_done,
	input wire [`PKT_W-1:0] pkt_bytes,
	output wire irq
);
	localparam ST_IDLE = 3'b001;
	localparam ST_RUN = 3'b010;
	localparam ST_WAIT = 3'b100;

	function [15:0] half_of;
		input [31:0] word;
		input which;
		begin
			half_of = which ? word[31:16] : word[15:0];
		end
	endfunction

	function mapped;
		input [7:0] addr;
		begin
			case (addr)
				`OFF_CTRL, `OFF_INTERVAL, `OFF_BUF_WORD, `OFF_PENDING,
				`OFF_STATUS, `OFF_MASK, `OFF_STATE: mapped = 1'b1;
				default: mapped = 1'b0;
			endcase
		end
	endfunction

	reg ctrl_double;
	reg ctrl_full_speed;
	reg ctrl_poll_en;
	reg [INTERVAL_W-1:0] interval;
	reg [31:0] buf_word;
	reg pending_flag;
	reg [`EVT_W-1:0] int_status;
	reg [`EVT_W-1:0] int_mask;
	reg sel;
	reg [2:0] state;
	reg [`LEN_W-1:0] remaining;
	reg [`LEN_W-1:0] total;
	reg is_poll;
	reg poll_pending;
	reg [2:0] next_state;
	reg [31:0] next_prdata;

	wire poll_due;
	wire [31:0] merged_word;
	wire [15:0] done_status;
	wire setup = psel & ~penable;
	wire access = psel & penable;
	wire wr = access & pwrite & mapped(paddr);
	wire rd = access & ~pwrite & mapped(paddr);
	wire sw_start = wr & (paddr == `OFF_CTRL) & pwdata[`CTRL_START];
	wire idle = (state == ST_IDLE);
	wire [`PKT_W-1:0] max_pkt = ctrl_full_speed ? `MAX_PKT_FULL : `MAX_PKT_LOW;
	wire [`LEN_W-1:0] max_len = {{(`LEN_W-`PKT_W){1'b0}}, max_pkt};
	wire [`LEN_W-1:0] got = {{(`LEN_W-`PKT_W){1'b0}}, pkt_bytes};
	wire [`LEN_W-1:0] taken = (got > remaining) ? remaining : got;
	wire last_pkt = (taken == remaining) || (pkt_bytes < pkt_size);
	wire finish = (state == ST_WAIT) & pkt_done & last_pkt;
	wire [`EVT_W-1:0] evt_set = {finish & is_poll, finish};
	wire status_read = rd & (paddr == `OFF_STATUS);
	wire [`EVT_W-1:0] next_status;
	genvar g;

	// Double buffering only for software transfers
	wire sw_is_poll_launch = ~sw_start & poll_pending;
	wire use_double = ctrl_double & ~sw_is_poll_launch;
	// Single mode always fetches the lower half
	wire [15:0] fetched = use_double ? half_of(buf_word, sel) : half_of(buf_word, 1'b0);

	// APB: no wait states; read data registered in the setup phase
	assign pready = 1'b1;
	assign pslverr = access & ~mapped(paddr);
	assign irq = |(int_status & int_mask);
	assign done_status = {1'b0, 1'b1, {(14-`LEN_W){1'b0}}, total + taken};

	// Due pulses while busy merge into one pending poll
	usb_poll_timer #(
		.INTERVAL_W(INTERVAL_W)
	) u_poll_timer (
		.pclk(pclk),
		.presetn(presetn),
		.enable(ctrl_poll_en),
		.interval(interval),
		.due(poll_due)
	);

	// Completion status goes to the half the selector names now
	usb_status_merge u_status_merge (
		.word_in(buf_word),
		.sel(sel),
		.status(done_status),
		.word_out(merged_word)
	);

	// Read data registered in the setup phase, held until the next read
	always @*
	begin
		case (paddr)
			`OFF_CTRL:
				next_prdata = {28'h000_0000, ctrl_poll_en, ctrl_full_speed, ctrl_double, 1'b0};
			`OFF_INTERVAL: next_prdata = {{(32-INTERVAL_W){1'b0}}, interval};
			`OFF_BUF_WORD: next_prdata = buf_word;
			`OFF_PENDING: next_prdata = {31'h0000_0000, pending_flag};
			`OFF_STATUS: next_prdata = {{(32-`EVT_W){1'b0}}, int_status};
			`OFF_MASK: next_prdata = {{(32-`EVT_W){1'b0}}, int_mask};
			`OFF_STATE: next_prdata = {27'h000_0000, is_poll, poll_pending, ~idle, 1'b0, sel};
			default: next_prdata = 32'h0000_0000;
		endcase
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (setup && !pwrite)
			prdata <= next_prdata;
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_double <= 1'b0;
			ctrl_full_speed <= 1'b0;
			ctrl_poll_en <= 1'b0;
			interval <= `RST_INTERVAL;
			int_mask <= `RST_EVT;
		end
		else if (wr)
		begin
			if (paddr == `OFF_CTRL)
			begin
				ctrl_double <= pwdata[`CTRL_DOUBLE];
				ctrl_full_speed <= pwdata[`CTRL_FULL_SPEED];
				ctrl_poll_en <= pwdata[`CTRL_POLL_EN];
			end
			if (paddr == `OFF_INTERVAL)
				interval <= pwdata[INTERVAL_W-1:0];
			if (paddr == `OFF_MASK)
				int_mask <= pwdata[`EVT_W-1:0];
		end
	end

	// Hardware write-back wins over a software write in the same cycle
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			buf_word <= `RST_WORD;
		else if (finish)
			buf_word <= merged_word;
		else if (wr && paddr == `OFF_BUF_WORD)
			buf_word <= pwdata;
	end

	// Read clears status; the set term is ORed last so a new event wins
	generate
		for (g = 0; g < `EVT_W; g = g + 1)
		begin : g_evt
			assign next_status[g] = evt_set[g] | (int_status[g] & ~status_read);
		end
	endgenerate

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			int_status <= `RST_EVT;
		else
			int_status <= next_status;
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pending_flag <= 1'b0;
		else if (finish)
			pending_flag <= sel;
	end

	// Poll held until the engine is free
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			poll_pending <= 1'b0;
		else if (poll_due)
			poll_pending <= 1'b1;
		else if (idle && !sw_start)
			poll_pending <= 1'b0;
	end

	// Unknown state codes fall back to idle
	// A stray pkt_done outside WAIT is ignored
	always @*
	begin
		next_state = state;
		case (state)
			ST_IDLE:
				if (sw_start || poll_pending)
					next_state = ST_RUN;
			ST_RUN:
				next_state = ST_WAIT;
			ST_WAIT:
				if (pkt_done)
					next_state = last_pkt ? ST_IDLE : ST_RUN;
			default:
				next_state = ST_IDLE;
		endcase
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state <= ST_IDLE;
			sel <= 1'b0;
			remaining <= {`LEN_W{1'b0}};
			total <= {`LEN_W{1'b0}};
			is_poll <= 1'b0;
			pkt_start <= 1'b0;
			pkt_size <= {`PKT_W{1'b0}};
			pkt_is_poll <= 1'b0;
		end
		else
		begin
			pkt_start <= 1'b0;
			// Transition chosen above; this block moves the data
			state <= next_state;
			case (state)
				ST_IDLE:
				begin
					// Selector kept from the last transfer, not reset
					if (sw_start || poll_pending)
					begin
						is_poll <= ~sw_start;
						remaining <= fetched[`LEN_W-1:0];
						total <= {`LEN_W{1'b0}};
					end
				end
				ST_RUN:
				begin
					// Longer transfers split at max packet size
					if (remaining > max_len)
						pkt_size <= max_pkt;
					else
						pkt_size <= remaining[`PKT_W-1:0];
					pkt_is_poll <= is_poll;
					pkt_start <= 1'b1;
				end
				ST_WAIT:
				begin
					if (pkt_done)
					begin
						// Toggles per packet whatever the buffering mode
						sel <= ~sel;
						remaining <= remaining - taken;
						total <= total + taken;
					end
				end
				default:
					state <= ST_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

/* File: usb_host_buffer_select_defs.vh */
// Offsets, field positions, reset values and packet limits of the
// USB host buffer selector. Definitions only; included by bare name.
`ifndef USB_HOST_BUFFER_SELECT_DEFS_VH
`define USB_HOST_BUFFER_SELECT_DEFS_VH

`define OFF_CTRL 8'h00
`define OFF_INTERVAL 8'h04
`define OFF_BUF_WORD 8'h08
`define OFF_PENDING 8'h0c
`define OFF_STATUS 8'h10
`define OFF_MASK 8'h14
`define OFF_STATE 8'h18

`define CTRL_START 0
`define CTRL_DOUBLE 1
`define CTRL_FULL_SPEED 2
`define CTRL_POLL_EN 3

`define HALF_FULL 15
`define HALF_DONE 14
`define LEN_W 10

`define EVT_BUF_DONE 0
`define EVT_POLL_DONE 1
`define EVT_W 2

`define MAX_PKT_LOW 7'h08
`define MAX_PKT_FULL 7'h40
`define PKT_W 7

`define RST_INTERVAL 16'h03e8
`define RST_WORD 32'h0000_0000
`define RST_EVT 2'h0

`endif

/* File: usb_status_merge.v */
// Places one 16-bit completion status into the selected half of a
// buffer control and status word. Purely combinational.
`timescale 1ns/10ps
`default_nettype none
module usb_status_merge
(
	input wire [31:0] word_in,
	input wire sel,
	input wire [15:0] status,
	output wire [31:0] word_out
);
	// Selector one lands the status in the upper half
	assign word_out = sel ? {status, word_in[15:0]} : {word_in[31:16], status};
endmodule
`default_nettype wire

/* File: usb_poll_timer.v */
// Interval counter for automatic interrupt-endpoint polls.
// Assumes one clock; interval counts pclk cycles, zero stops it.
`timescale 1ns/10ps
`default_nettype none
module usb_poll_timer
#(
	parameter INTERVAL_W = 16
)
(
	input wire pclk,
	input wire presetn,
	input wire enable,
	input wire [INTERVAL_W-1:0] interval,
	output reg due
);
	reg [INTERVAL_W-1:0] count;

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			count <= {INTERVAL_W{1'b0}};
			due <= 1'b0;
		end
		else if (!enable || interval == {INTERVAL_W{1'b0}})
		begin
			count <= {INTERVAL_W{1'b0}};
			due <= 1'b0;
		end
		else if (count >= interval - 1'b1)
		begin
			count <= {INTERVAL_W{1'b0}};
			due <= 1'b1;
		end
		else
		begin
			count <= count + 1'b1;
			due <= 1'b0;
		end
	end
endmodule
`default_nettype wire

/* File: usb_hbs_props.sv */
// Port checker of the USB host buffer selector.
// Assumes one clock pclk and the reset presetn.
`timescale 1ns/10ps
`default_nettype none
module usb_hbs_props
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic pkt_start,
	input wire logic [6:0] pkt_size,
	input wire logic pkt_is_poll,
	input wire logic pkt_done,
	input wire logic [6:0] pkt_bytes,
	input wire logic irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_short;
		pkt_done && pkt_bytes < pkt_size;
	endsequence
	sequence s_quiet;
		!pkt_start [*3];
	endsequence
	a_ready_high: assert property (pready) else $error("pready low");
	a_bad_addr: assert property (psel && penable && paddr > 8'h18 |-> pslverr)
		else $error("no slave error");
	a_start_gap: assert property (pkt_start |=> s_quiet) else $error("start too soon");
	a_short_ends: assert property (s_short |=> !pkt_start [*2]) else $error("short kept on");
	a_size_limit: assert property (pkt_start |-> pkt_size != 7'h00 && pkt_size <= 7'h40)
		else $error("bad packet size");
	a_size_hold: assert property (!$stable(pkt_size) |-> pkt_start) else $error("size moved");
	a_rdata_hold: assert property (!$stable(prdata) |-> $past(psel && !penable && !pwrite))
		else $error("read data moved");
	a_irq_cause: assert property ($rose(irq) |-> $past(pkt_done || psel && penable && pwrite))
		else $error("irq without cause");
	a_irq_clear: assert property (psel && penable && !pwrite && paddr == 8'h10 && !pkt_done
		|=> !irq) else $error("irq not cleared");
endmodule
bind usb_host_buffer_select usb_hbs_props i_props (.*);
`default_nettype wire

/* File: usb_packet_peer.sv */
// Far-side peripheral: answers each packet request lag plus two cycles after it.
// Assumes requests come as one-cycle pulses; cut answers one byte short.
`timescale 1ns/10ps
`default_nettype none
module usb_packet_peer
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pkt_start,
	input wire logic [6:0] pkt_size,
	input wire logic [3:0] lag,
	input wire logic cut,
	output logic pkt_done,
	output logic [6:0] pkt_bytes
);
	logic [3:0] n;
	logic [6:0] sz;
	always @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			n <= 4'h0;
			sz <= 7'h00;
			pkt_done <= 1'h0;
			pkt_bytes <= 7'h00;
		end
		else
		begin
			pkt_done <= 1'h0;
			// Stale count is inverted so it is never mistaken for an answer
			pkt_bytes <= ~pkt_bytes;
			if (pkt_start)
			begin
				n <= lag + 4'h1;
				sz <= pkt_size;
			end
			else if (n == 4'h1)
			begin
				n <= 4'h0;
				pkt_done <= 1'h1;
				pkt_bytes <= cut ? sz - 7'h01 : sz;
			end
			else if (n != 4'h0)
				n <= n - 4'h1;
		end
endmodule
`default_nettype wire

/* File: usb_host_buffer_select_bench.sv */
// Self-checking bench of the USB host buffer selector.
// Assumes the packet peer model and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module usb_host_buffer_select_bench;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, cut = 0;
	logic pready, pslverr, irq, pkt_start, pkt_is_poll, pkt_done, er, last_poll;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rdat;
	logic [6:0] pkt_size, pkt_bytes, last_size;
	logic [3:0] lag = 1;
	int fail_count = 0, checks_done = 0, i;
	always #20 pclk = ~pclk;
	always @(posedge pclk)
		if (pkt_start)
			{last_poll, last_size} <= {pkt_is_poll, pkt_size};
	usb_host_buffer_select i_dut (.*);
	usb_packet_peer i_peer (.*);
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			$display("Error at %0t: got %h exp %h", $time, got, exp);
			fail_count++;
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1)
			@(posedge pclk);
		rdat = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'h0, a, 32'h0000_0000);
		chk(rdat, e);
	endtask
	task wait_irq;
		i = 0;
		while (irq !== 1'h1 && i < 300)
		begin
			@(posedge pclk);
			i++;
		end
		chk(32'(irq), 32'h0000_0001);
	endtask
	task t_reset;
		rd(8'h04, 32'h0000_03e8);
		rd(8'h10, 32'h0000_0000);
		rd(8'h18, 32'h0000_0000);
		rd(8'h1c, 32'h0000_0000);
		chk(32'(er), 32'h0000_0001);
		bus(1'h1, 8'h14, 32'h0000_0003);
		$display("reset test done");
	endtask
	task t_single;
		bus(1'h1, 8'h08, 32'h0000_8010);
		bus(1'h1, 8'h00, 32'h0000_0001);
		wait_irq;
		chk(32'(last_size), 32'h0000_0008);
		chk(32'(last_poll), 32'h0000_0000);
		rd(8'h08, 32'h4010_8010);
		chk(rdat >> 16, 32'h0000_4010);
		rd(8'h0c, 32'h0000_0001);
		rd(8'h18, 32'h0000_0000);
		bus(1'h1, 8'h14, 32'h0000_0000);
		chk(32'(irq), 32'h0000_0000);
		bus(1'h1, 8'h14, 32'h0000_0003);
		chk(32'(irq), 32'h0000_0001);
		rd(8'h10, 32'h0000_0001);
		chk(32'(irq), 32'h0000_0000);
		$display("single buffer test done");
	endtask
	task t_poll;
		bus(1'h1, 8'h08, 32'h0000_8005);
		bus(1'h1, 8'h00, 32'h0000_0001);
		wait_irq;
		rd(8'h10, 32'h0000_0001);
		rd(8'h18, 32'h0000_0001);
		bus(1'h1, 8'h08, 32'h0000_8005);
		// Interval long enough that only one poll runs before the stop
		bus(1'h1, 8'h04, 32'h0000_0028);
		bus(1'h1, 8'h00, 32'h0000_0008);
		wait_irq;
		// Polls stopped at once so a second poll cannot disturb the word
		bus(1'h1, 8'h00, 32'h0000_0000);
		chk(32'(last_poll), 32'h0000_0001);
		chk(32'(last_size), 32'h0000_0005);
		rd(8'h10, 32'h0000_0003);
		rd(8'h0c, 32'h0000_0001);
		rd(8'h08, 32'h4005_8005);
		$display("poll test done");
	endtask
	task t_full;
		lag <= 4'h6;
		cut <= 1'h1;
		bus(1'h1, 8'h08, 32'h0000_8064);
		bus(1'h1, 8'h00, 32'h0000_0005);
		wait_irq;
		chk(32'(last_size), 32'h0000_0040);
		rd(8'h08, 32'h0000_403f);
		rd(8'h0c, 32'h0000_0000);
		rd(8'h10, 32'h0000_0001);
		$display("full speed test done");
	endtask
	task conclude;
		$display("checks %0d fails %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		repeat (4) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		t_reset;
		t_single;
		t_poll;
		t_full;
		conclude;
	end
	initial
	begin
		#200000;
		fail_count++;
		conclude;
	end
endmodule
`default_nettype wire
